// ### pkg/serial_lane_defines.vh
// constants for the gigabit serial lane control block
// assumes inclusion by bare name from rtl files
`ifndef SERIAL_LANE_DEFINES_VH
`define SERIAL_LANE_DEFINES_VH

// register word addresses
`define ADDR_COMMON      4'h0
`define ADDR_PLL         4'h1
`define ADDR_DES         4'h2
`define ADDR_MISC        4'h3
`define ADDR_STATUS      4'h4
`define ADDR_LIMIT       4'h5

// common register fields
`define COM_LANE_ENA     0
`define COM_MACRO_SYSTEM_RESET_N    1
`define COM_ELOOP        2
`define COM_FLOOP        3
`define COM_RECO_LOCAL   4
`define COM_RECO_SHARED  5
`define COM_SQL_LOCAL    6
`define COM_SQL_SHARED   7
`define COM_WIDTH        8
`define COM_RESET        8'h00

// pll register: [7:0] control value, [8] calibration enable
`define PLL_CALIB_ENA    8
`define PLL_CTRL_1G25    8'hc8
`define PLL_RESET        9'h000

// deserializer register: [2:0] time constant, [5:3] prop bw, [9:6] phase ctrl
`define DES_TC_LSB       0
`define DES_BW_LSB       3
`define DES_PHS_LSB      6
`define DES_TC_DEFAULT   3'h5
`define DES_TC_MIN       3'h3
`define DES_TC_MAX       3'h7
`define DES_BW_MIN       3'h4
`define DES_BW_MAX       3'h7
`define DES_RESET        10'h0e5

// misc register: [0] lane reset (high holds reset), [1] fiber 100M mode
`define MISC_LANE_RST    0
`define MISC_FX100       1
`define MISC_RESET       2'h1

// calibration timing
`define CALIB_TIME_NS    1000
`define CLK_PERIOD_NS    25
`define CALIB_CYCLES     ((`CALIB_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// fiber oversampling ratio: 1 Gbps over 100 Mbps
`define FX_OVERSAMPLE    10

// frequency offset limits in ppm for prop bw 4..7
`define LIMIT_BW4        16'd1953
`define LIMIT_BW5        16'd977
`define LIMIT_BW6        16'd488
`define LIMIT_BW7        16'd244

// integrator loop constants
`define INT_SCALE_128    128
`define INT_SCALE_32     32

`endif

// ### rtl/serial_lane_ctrl.v
// control logic of one gigabit serial lane: reset, pll calibration,
// loopback routing, recovered clock routing and the pi phase regulator.
// assumes a single ref_clk domain and a register port with one-cycle reads;
// serial data are modelled as parallel 10-bit words at the word rate.
`timescale 1ns/1ps
`default_nettype none
`include "serial_lane_defines.vh"

// Behaviour
// - lane carries 1 Gbps words, fiber mode oversamples the received stream
// - lane works only while software sets the lane enable bit
// - lane stays reset until macro reset and lane reset both released
// - reset low with calibration off, then both high starts calibration
// - equipment loop feeds serializer into deserializer, transmit still visible
// - facility loop retransmits received data words
// - recovered clock drives local and shared outputs per their selects
// - auto-squelch hides recovered clock while pcs sees no valid data
// - pi loop, integrator clamped by phase control below proportional
// - integrator time constant accepts 3 to 7, smaller is faster
// - integrator step period scales as 16*2^(tc+1-bw) word periods, the 128*32 factor scaled to 16
// - integrator settles, toggling between two adjacent values
// - proportional bandwidth field sets proportional gain, lowest fastest
// - offset limits 1953, 977, 488, 244 ppm for settings 4 to 7
module serial_lane_ctrl #(
	parameter CALIB_CYCLES = `CALIB_CYCLES,
	parameter WORD_W       = 10
) (
	input  wire              ref_clk,
	input  wire              rst_n,
	input  wire [3:0]        reg_addr,
	input  wire [31:0]       reg_wdata,
	input  wire              reg_wr,
	input  wire              reg_rd,
	output reg  [31:0]       reg_rdata,
	input  wire [WORD_W-1:0] tx_word,
	input  wire [WORD_W-1:0] rx_serial_word,
	input  wire              rx_edge_early,
	input  wire              rx_edge_late,
	input  wire              pcs_data_valid,
	input  wire              rx_clk_in,
	output reg  [WORD_W-1:0] tx_serial_word,
	output reg  [WORD_W-1:0] rx_word,
	output reg               rx_word_valid,
	output wire              reco_clk_local,
	output wire              reco_clk_shared,
	output wire              reco_clk_shared_oe,
	output reg  [7:0]        pll_ctrl_value,
	output reg               pll_calib_start,
	output reg  [7:0]        phase_step,
	output wire              lane_active
);

	localparam ST_RESET = 2'd0;
	localparam ST_CALIB = 2'd1;
	localparam ST_READY = 2'd2;

	reg [`COM_WIDTH-1:0] common_reg;
	reg [8:0]            pll_reg;
	reg [9:0]            des_reg;
	reg [1:0]            misc_reg;
	reg [1:0]            state_reg;
	reg [1:0]            state_next;
	reg [15:0]           calib_cnt_reg;
	reg                  calib_done_reg;
	reg                  prev_armed_reg;
	reg [3:0]            fx_cnt_reg;
	reg signed [15:0]    integ_reg;
	reg [23:0]           int_tick_reg;
	reg                  ppm_limit_hit_reg;

	wire       eloop_on;
	wire       floop_on;
	wire [2:0] tc_field;
	wire [2:0] bw_field;
	wire [3:0] phs_field;
	wire [2:0] tc_eff;
	wire [2:0] bw_eff;
	wire       armed;
	wire       lane_up;
	wire [WORD_W-1:0] des_in;
	wire [7:0]        prop_step;
	wire [3:0]        integ_lim;
	wire [4:0]        int_shift;
	wire signed [15:0] lim_pos;

	// clamp a 3-bit field into its allowed window
	function [2:0] clamp3;
		input [2:0] v;
		input [2:0] lo;
		input [2:0] hi;
		begin
			if (v < lo)
				clamp3 = lo;
			else if (v > hi)
				clamp3 = hi;
			else
				clamp3 = v;
		end
	endfunction

	// ppm limit per proportional bandwidth setting
	function [15:0] bw_limit;
		input [2:0] bw;
		begin
			case (bw)
				3'h4:    bw_limit = `LIMIT_BW4;
				3'h5:    bw_limit = `LIMIT_BW5;
				3'h6:    bw_limit = `LIMIT_BW6;
				default: bw_limit = `LIMIT_BW7;
			endcase
		end
	endfunction

	assign tc_field  = des_reg[`DES_TC_LSB +: 3];
	assign bw_field  = des_reg[`DES_BW_LSB +: 3];
	assign phs_field = des_reg[`DES_PHS_LSB +: 4];
	// time constant window
	// values outside the window clamp rather than wrap, so a bad write stays safe
	assign tc_eff = clamp3(tc_field, `DES_TC_MIN, `DES_TC_MAX);
	// only settings 4 to 7 apply
	assign bw_eff = clamp3(bw_field, `DES_BW_MIN, `DES_BW_MAX);

	// proportional step halves for each bandwidth setting above 4
	assign prop_step = 8'h40 >> (bw_eff - `DES_BW_MIN);
	// integrator limit capped below the proportional step, so the
	// proportional part stays stronger whatever phase control asks for;
	// with bandwidth 7 this caps the limit at 7
	assign integ_lim = ({4'h0, phs_field} < prop_step) ? phs_field : prop_step[3:0] - 4'h1;
	assign lim_pos   = $signed({12'h000, integ_lim});
	// period exponent widened so time constant 7 with bandwidth 4 cannot wrap
	assign int_shift = {2'b00, tc_eff} + 5'd5 - {2'b00, bw_eff};

	// equipment loop wins when both are set
	assign eloop_on = common_reg[`COM_ELOOP];
	assign floop_on = common_reg[`COM_FLOOP] & ~common_reg[`COM_ELOOP];

	// both resets released; lane enable and the ready state join in lane_up
	assign armed = common_reg[`COM_MACRO_SYSTEM_RESET_N] & ~misc_reg[`MISC_LANE_RST];
	assign lane_up     = common_reg[`COM_LANE_ENA] & armed & (state_reg == ST_READY);
	assign lane_active = lane_up;

	// register writes
	// status and limit words are read-only; writes to them fall through to default
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			common_reg <= `COM_RESET;
			pll_reg    <= `PLL_RESET;
			des_reg    <= `DES_RESET;
			misc_reg   <= `MISC_RESET;
		end else if (reg_wr) begin
			case (reg_addr)
				`ADDR_COMMON: common_reg <= reg_wdata[`COM_WIDTH-1:0];
				`ADDR_PLL:    pll_reg    <= reg_wdata[8:0];
				`ADDR_DES:    des_reg    <= reg_wdata[9:0];
				`ADDR_MISC:   misc_reg   <= reg_wdata[1:0];
				default:      ;
			endcase
		end
	end

	// register reads, data one cycle after the strobe; unmapped reads zero
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			reg_rdata <= 32'h0000_0000;
		end else if (reg_rd) begin
			case (reg_addr)
				`ADDR_COMMON: reg_rdata <= {24'h000000, common_reg};
				`ADDR_PLL:    reg_rdata <= {23'h0, pll_reg};
				`ADDR_DES:    reg_rdata <= {22'h0, des_reg};
				`ADDR_MISC:   reg_rdata <= {30'h0, misc_reg};
				`ADDR_STATUS: reg_rdata <= {integ_reg, 11'h000, ppm_limit_hit_reg,
					lane_up, calib_done_reg, state_reg};
				`ADDR_LIMIT:  reg_rdata <= {16'h0000, bw_limit(bw_eff)};
				default:      reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// start-up sequencer next state
	always @* begin
		state_next = state_reg;
		case (state_reg)
			ST_RESET: begin
				// calibration starts when armed and calib enable first become both high
				if (armed && pll_reg[`PLL_CALIB_ENA] && !prev_armed_reg)
					state_next = ST_CALIB;
			end
			ST_CALIB: begin
				if (!armed || !pll_reg[`PLL_CALIB_ENA])
					state_next = ST_RESET;
				else if (calib_cnt_reg == CALIB_CYCLES[15:0] - 16'd1)
					state_next = ST_READY;
			end
			ST_READY: begin
				if (!armed)
					state_next = ST_RESET;
			end
			default: state_next = ST_RESET;
		endcase
	end

	// sequencer registers; prev_armed needs the reset-low phase first
	// calibration reruns only after armed and enable drop, so rewrites cannot retrigger it
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			state_reg       <= ST_RESET;
			calib_cnt_reg   <= 16'h0000;
			calib_done_reg  <= 1'b0;
			prev_armed_reg  <= 1'b1;
			pll_ctrl_value  <= 8'h00;
			pll_calib_start <= 1'b0;
		end else begin
			state_reg      <= state_next;
			prev_armed_reg <= armed & pll_reg[`PLL_CALIB_ENA];
			// control value latched when calibration starts
			pll_calib_start <= (state_reg == ST_RESET) && (state_next == ST_CALIB);
			if ((state_reg == ST_RESET) && (state_next == ST_CALIB))
				pll_ctrl_value <= pll_reg[7:0];
			calib_cnt_reg  <= (state_reg == ST_CALIB) ? calib_cnt_reg + 16'd1 : 16'h0000;
			calib_done_reg <= (state_next == ST_READY);
		end
	end

	// equipment loop feeds serializer into deserializer
	assign des_in = eloop_on ? tx_word : rx_serial_word;

	// data path with fiber oversampling
	// serializer idles at zero while the lane is down, so the far end sees no stale words
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			tx_serial_word <= {WORD_W{1'b0}};
			rx_word        <= {WORD_W{1'b0}};
			rx_word_valid  <= 1'b0;
			fx_cnt_reg     <= 4'h0;
		end else if (!lane_up) begin
			tx_serial_word <= {WORD_W{1'b0}};
			rx_word_valid  <= 1'b0;
			fx_cnt_reg     <= 4'h0;
		end else begin
			// facility loop retransmits the received word
			tx_serial_word <= floop_on ? rx_serial_word : tx_word;
			// fiber mode keeps one word in ten
			if (misc_reg[`MISC_FX100]) begin
				fx_cnt_reg    <= (fx_cnt_reg == `FX_OVERSAMPLE - 1) ? 4'h0 : fx_cnt_reg + 4'h1;
				rx_word_valid <= (fx_cnt_reg == 4'h0);
			end else begin
				fx_cnt_reg    <= 4'h0;
				rx_word_valid <= 1'b1;
			end
			rx_word <= des_in;
		end
	end

	// recovered clock routing, squelch when pcs invalid
	// gating is a plain and, so a select change can clip one recovered clock pulse
	assign reco_clk_local = rx_clk_in & lane_up & common_reg[`COM_RECO_LOCAL]
		& ~(common_reg[`COM_SQL_LOCAL] & ~pcs_data_valid);
	assign reco_clk_shared = rx_clk_in & lane_up & common_reg[`COM_RECO_SHARED]
		& ~(common_reg[`COM_SQL_SHARED] & ~pcs_data_valid);
	assign reco_clk_shared_oe = lane_up & common_reg[`COM_RECO_SHARED];

	// pi regulator: integrator steps slowly, proportional acts every word
	// the integrator restarts from zero whenever the lane drops, so a relock
	// learns the offset again; cheaper than keeping stale state around
	always @(posedge ref_clk) begin
		if (!rst_n || !lane_up) begin
			integ_reg         <= 16'sd0;
			int_tick_reg      <= 24'h000000;
			phase_step        <= 8'h00;
			ppm_limit_hit_reg <= 1'b0;
		end else begin
			// integrator period 2^(tc+5-bw) words, the 128*32 factor scaled to 16
			if (int_tick_reg >= (24'h000001 << int_shift) - 24'h000001) begin
				int_tick_reg <= 24'h000000;
				// one lsb steps make it toggle at the settled value
				if (rx_edge_early && integ_reg < lim_pos)
					integ_reg <= integ_reg + 16'sd1;
				else if (rx_edge_late && integ_reg > -lim_pos)
					integ_reg <= integ_reg - 16'sd1;
			end else begin
				int_tick_reg <= int_tick_reg + 24'h000001;
			end
			ppm_limit_hit_reg <= (integ_lim != 4'h0) &&
				((integ_reg == lim_pos) || (integ_reg == -lim_pos));
			// proportional gain from bandwidth, lowest value strongest
			phase_step <= integ_reg[7:0]
				+ (rx_edge_early ? prop_step : 8'h00)
				- (rx_edge_late  ? prop_step : 8'h00);
		end
	end

endmodule // serial_lane_ctrl
`default_nettype wire

// ### sim/serial_lane_ctrl_asserts.sv
// port checker for serial_lane_ctrl
// assumes bind to the design top, one ref_clk domain
`timescale 1ns/1ps
`default_nettype none
`include "serial_lane_defines.vh"
module serial_lane_ctrl_asserts #(
	parameter CALIB_CYCLES = 40
) (
	input wire        ref_clk,
	input wire        rst_n,
	input wire [3:0]  reg_addr,
	input wire [31:0] reg_wdata,
	input wire        reg_wr,
	input wire [9:0]  tx_word,
	input wire [9:0]  rx_serial_word,
	input wire        pcs_data_valid,
	input wire        rx_clk_in,
	input wire [9:0]  tx_serial_word,
	input wire [9:0]  rx_word,
	input wire        reco_clk_local,
	input wire        reco_clk_shared,
	input wire        reco_clk_shared_oe,
	input wire        pll_calib_start,
	input wire        lane_active
);
	reg [7:0] com_reg;
	reg       pll_ena_reg;
	reg       lane_rst_reg;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// shadow of software settings, live the cycle after a write
	always @(posedge ref_clk) begin
		if (!rst_n) begin
			com_reg <= 8'h00;
			pll_ena_reg <= 1'b0;
			lane_rst_reg <= 1'b1;
		end else if (reg_wr) begin
			if (reg_addr == `ADDR_COMMON) com_reg <= reg_wdata[7:0];
			if (reg_addr == `ADDR_PLL) pll_ena_reg <= reg_wdata[8];
			if (reg_addr == `ADDR_MISC) lane_rst_reg <= reg_wdata[0];
		end
	end
	property p_lane_gate;
		lane_active |-> com_reg[0] && com_reg[1] && !lane_rst_reg;
	endproperty
	a_lane_gate: assert property (p_lane_gate) else $error("lane up too early");
	property p_calib_ok;
		pll_calib_start |-> pll_ena_reg && com_reg[1] && !lane_rst_reg;
	endproperty
	a_calib_ok: assert property (p_calib_ok) else $error("bad calib start");
	property p_calib_len;
		pll_calib_start |-> !lane_active [*4];
	endproperty
	a_calib_len: assert property (p_calib_len) else $error("calib too short");
	property p_eloop_rx;
		lane_active && com_reg[2] |=> rx_word == $past(tx_word);
	endproperty
	a_eloop_rx: assert property (p_eloop_rx) else $error("eloop rx");
	property p_eloop_tx;
		lane_active && com_reg[2] |=> tx_serial_word == $past(tx_word);
	endproperty
	a_eloop_tx: assert property (p_eloop_tx) else $error("eloop tx");
	property p_floop;
		lane_active && com_reg[3] && !com_reg[2] |=> tx_serial_word == $past(rx_serial_word);
	endproperty
	a_floop: assert property (p_floop) else $error("floop tx");
	property p_reco_local;
		lane_active |-> reco_clk_local ==
			(rx_clk_in && com_reg[4] && (pcs_data_valid || !com_reg[6]));
	endproperty
	a_reco_local: assert property (p_reco_local) else $error("local clock");
	property p_reco_shared;
		lane_active |-> reco_clk_shared ==
			(rx_clk_in && com_reg[5] && (pcs_data_valid || !com_reg[7]));
	endproperty
	a_reco_shared: assert property (p_reco_shared) else $error("shared clock");
	property p_shared_oe;
		!com_reg[5] |-> !reco_clk_shared_oe;
	endproperty
	a_shared_oe: assert property (p_shared_oe) else $error("shared oe");
	property p_shared_oe_on;
		lane_active && com_reg[5] |-> reco_clk_shared_oe;
	endproperty
	a_shared_oe_on: assert property (p_shared_oe_on) else $error("shared oe off");
endmodule // serial_lane_ctrl_asserts
bind serial_lane_ctrl serial_lane_ctrl_asserts #(.CALIB_CYCLES(CALIB_CYCLES)) u_chk (
	.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .tx_word(tx_word), .rx_serial_word(rx_serial_word),
	.pcs_data_valid(pcs_data_valid), .rx_clk_in(rx_clk_in), .tx_serial_word(tx_serial_word),
	.rx_word(rx_word), .reco_clk_local(reco_clk_local), .reco_clk_shared(reco_clk_shared),
	.reco_clk_shared_oe(reco_clk_shared_oe), .pll_calib_start(pll_calib_start),
	.lane_active(lane_active));
`default_nettype wire

// ### sim/link_partner.sv
// remote link partner: received words and recovered clock
// assumes word-rate sampling on ref_clk; clock runs only while linked, words invert each cycle while idle
`timescale 1ns/1ps
`default_nettype none
module link_partner (
	input  wire        ref_clk,
	input  wire        active,
	output logic [9:0] rx_serial_word,
	output logic       rx_clk_in
);
	initial begin
		rx_serial_word = 10'h155;
		rx_clk_in = 1'b0;
	end
	always @(posedge ref_clk)
		rx_serial_word <= active ? rx_serial_word + 10'h0b3 : ~rx_serial_word;
	// clock stands still while the link is idle
	always #7.3 if (active) rx_clk_in = ~rx_clk_in;
endmodule // link_partner
`default_nettype wire

// ### sim/testbench.sv
// self-checking bench for serial_lane_ctrl
// assumes design, defines and partner model compiled first
`timescale 1ns/1ps
`default_nettype none
`include "serial_lane_defines.vh"
module testbench;
	localparam CAL = 4;
	logic        ref_clk, rst_n, reg_wr, reg_rd, link;
	logic        pcs_data_valid, rx_edge_early, rx_edge_late;
	logic [3:0]  reg_addr;
	logic [31:0] reg_wdata, rd_val;
	logic [9:0]  tx_word;
	logic [1:0]  pd_force = 2'b00;
	logic [31:0] rnd;
	wire  [31:0] reg_rdata;
	wire  [9:0]  rx_serial_word, tx_serial_word, rx_word;
	wire  [7:0]  pll_ctrl_value, phase_step;
	wire         rx_clk_in, rx_word_valid, reco_clk_local, reco_clk_shared;
	wire         reco_clk_shared_oe, pll_calib_start, lane_active;
	integer      bad_count = 0, check_count = 0, seed = 32'hdc22, i, n, md;
	integer      exq[$];
	logic [31:0] rst_tab [0:6] = '{0, 0, `DES_RESET, `MISC_RESET, 0, `LIMIT_BW4, 0};
	serial_lane_ctrl #(.CALIB_CYCLES(CAL)) i_serial_lane_ctrl (.ref_clk(ref_clk),
		.rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .tx_word(tx_word),
		.rx_serial_word(rx_serial_word), .rx_edge_early(rx_edge_early),
		.rx_edge_late(rx_edge_late), .pcs_data_valid(pcs_data_valid), .rx_clk_in(rx_clk_in),
		.tx_serial_word(tx_serial_word), .rx_word(rx_word), .rx_word_valid(rx_word_valid),
		.reco_clk_local(reco_clk_local), .reco_clk_shared(reco_clk_shared),
		.reco_clk_shared_oe(reco_clk_shared_oe), .pll_ctrl_value(pll_ctrl_value),
		.pll_calib_start(pll_calib_start), .phase_step(phase_step), .lane_active(lane_active));
	link_partner i_link_partner (.ref_clk(ref_clk), .active(link),
		.rx_serial_word(rx_serial_word), .rx_clk_in(rx_clk_in));
	initial begin
		ref_clk = 1'b0;
		forever #12.5 ref_clk = ~ref_clk;
	end
	// random pcs words and phase detector levels every cycle
	// a nonzero pd_force holds the phase detector levels for the regulator test
	always @(posedge ref_clk) begin
		rnd = $random(seed);
		{tx_word, pcs_data_valid} <= rnd[12:2];
		{rx_edge_early, rx_edge_late} <= (pd_force != 2'b00) ? pd_force : rnd[1:0];
	end
	task automatic chk(input [31:0] got, input [31:0] exp);
		check_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task automatic wr(input [3:0] a, input [31:0] d);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input [3:0] a, output [31:0] d);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask
	// bounded wait on calib pulse (0) or lane up (1)
	task automatic wait_sig(input integer sel);
		n = 0;
		while ((sel ? lane_active : pll_calib_start) !== 1'b1) begin
			@(posedge ref_clk);
			#1 n++;
			if (n > 60) begin
				$display("[ERR] %0t timeout", $time);
				bad_count++;
				break;
			end
		end
	endtask
	// data path model: expectations queued one cycle ahead
	task automatic run(input integer cyc, input integer el, input integer fl);
		integer k;
		exq.delete();
		for (k = 0; k <= cyc; k++) begin
			@(posedge ref_clk);
			#1;
			if (k > 0) begin
				chk(tx_serial_word, exq.pop_front());
				chk(rx_word, exq.pop_front());
				chk(rx_word_valid, 1);
			end
			exq.push_back((fl && !el) ? rx_serial_word : tx_word);
			exq.push_back(el ? tx_word : rx_serial_word);
		end
	endtask
	// hold one detector level, then the integrator must sit at its limit
	task automatic pi_run(input [1:0] f, input integer lim);
		integer s, g;
		pd_force <= f;
		repeat (200) @(posedge ref_clk);
		rd(`ADDR_STATUS, rd_val);
		s = $signed(rd_val[31:16]);
		g = $signed(phase_step);
		chk(rd_val[4], 1);
		if (lim > 0) chk(s, f[1] ? lim : -lim);
		chk(f[1] ? (g - s > s && s > 0) : (s - g > -s && s < 0), 1);
	endtask
	initial begin
		{rst_n, reg_wr, reg_rd, reg_addr, reg_wdata, link} = '0;
		{tx_word, pcs_data_valid, rx_edge_early, rx_edge_late} = '0;
		repeat (12) @(posedge ref_clk);
		rst_n <= 1'b1;
		link <= 1'b1;
		for (i = 0; i < 7; i++) begin
			rd(i[3:0], rd_val);
			chk(rd_val, rst_tab[i]);
		end
		$display("reset values done");
		// both reset and calib enable are low out of reset
		wr(`ADDR_PLL, 32'd200);
		wr(`ADDR_MISC, 32'h0);
		wr(`ADDR_COMMON, 32'h3);
		wr(`ADDR_PLL, 32'h1c8);
		wait_sig(0);
		wait_sig(1);
		chk(n >= CAL && n <= CAL + 1, 1);
		chk(pll_ctrl_value, 200);
		rd(`ADDR_STATUS, rd_val);
		chk(rd_val[3:0], 4'he);
		$display("startup done");
		// modes 0-2 keep at most one loopback, one lane; mode 3 is
		for (md = 0; md < 4; md++) begin
			wr(`ADDR_COMMON, 32'({md[1:0], 2'b11}) | (32'($random(seed)) & 32'hf0));
			run(20, md[0], md[1]);
			$display("loop mode %0d done", md);
		end
		wr(`ADDR_MISC, 32'h2);
		repeat (2) @(posedge ref_clk);
		n = 0;
		for (i = 0; i < 30; i++) begin
			@(posedge ref_clk);
			#1 n += rx_word_valid;
		end
		chk(n, 3);
		wr(`ADDR_MISC, 32'h0);
		// tc kept at 5, bw 2 to 7 tried as software picks one per offset
		for (i = 2; i < 8; i++) begin
			wr(`ADDR_DES, 32'h0c5 | 32'(i << 3));
			rd(`ADDR_LIMIT, rd_val);
			chk(rd_val, i <= 4 ? `LIMIT_BW4 : i == 5 ? `LIMIT_BW5 : i == 6 ? `LIMIT_BW6 : `LIMIT_BW7);
		end
		$display("limits done");
		// tc 3: bw 4 with phase control 5, then bw 7 with phase control 15
		for (i = 0; i < 2; i++) begin
			wr(`ADDR_DES, i ? 32'h3fb : 32'h163);
			pi_run(2'b10, i ? 0 : 5);
			pi_run(2'b01, i ? 0 : 5);
		end
		pd_force <= 2'b00;
		$display("phase regulator done");
		wr(`ADDR_COMMON, 32'h2);
		@(posedge ref_clk);
		#1 chk(lane_active, 0);
		summarize;
	end
endmodule // testbench
`default_nettype wire
